// ---- logic/tftst_consts.svh ----
// timing block constants: register offsets, field positions, reset values
// assumes inclusion from the package, the design modules and the bench
`ifndef TFTST_CONSTS_SVH
`define TFTST_CONSTS_SVH

// register byte offsets on the avalon word bus
`define TFTST_OFS_CTRL        6'h00
`define TFTST_OFS_SIZE        6'h04
`define TFTST_OFS_LINE        6'h08
`define TFTST_OFS_FRAME       6'h0C
`define TFTST_OFS_POL         6'h10
`define TFTST_OFS_CLKDIV      6'h14
`define TFTST_OFS_STATUS      6'h18
`define TFTST_OFS_PIXEL       6'h1C

// field positions
`define TFTST_SIZE_X_LSB      0
`define TFTST_SIZE_Y_LSB      16
`define TFTST_PAR_SW_LSB      0
`define TFTST_PAR_BP_LSB      8
`define TFTST_PAR_FP_LSB      16
`define TFTST_POL_LINE_BIT    0
`define TFTST_POL_FRAME_BIT   1
`define TFTST_DIV_LSB         0
`define TFTST_DLY_LSB         8
`define TFTST_INV_BIT         16

// reset values
`define TFTST_RST_SIZE        32'h01E0_0280
`define TFTST_RST_LINE        32'h0028_2830
`define TFTST_RST_FRAME       32'h000A_2002
`define TFTST_RST_POL         32'h0000_0000
`define TFTST_RST_CLKDIV      32'h0000_0002

// fastest pixel clock period in picoseconds and its least divider
`define TFTST_TPCP_MIN_PS     11200
`define TFTST_CLK_PERIOD_PS   5000
`define TFTST_DIV_MIN \
   ((`TFTST_TPCP_MIN_PS + `TFTST_CLK_PERIOD_PS - 1) / `TFTST_CLK_PERIOD_PS)

`endif

// ---- logic/tftst_pkg.sv ----
// types shared by the panel timing block
// assumes the constants header sits beside it
`include "tftst_consts.svh"
package tftst_pkg;
   // line and frame phases, one-hot
   typedef enum logic [3:0] {
      TFTST_SYNC   = 4'h1,
      TFTST_BACK   = 4'h2,
      TFTST_ACTIVE = 4'h4,
      TFTST_FRONT  = 4'h8
   } tftst_phase_t;

   // interval set used by one axis counter
   typedef struct packed {
      logic [15:0] syncWidth;
      logic [15:0] backPorch;
      logic [15:0] activeCount;
      logic [15:0] frontPorch;
   } tftst_axis_t;

   // panel-facing pins
   typedef struct packed {
      logic        pixelClock;
      logic        lineSync;
      logic        frameSync;
      logic        activeDataWindow;
      logic [23:0] pixelData;
   } tftst_panel_t;
endpackage : tftst_pkg

// ---- logic/tftst_axis_counter.sv ----
// one axis of display timing: walks sync, back porch, active, front porch
// assumes a one-cycle step pulse and intervals held stable by the caller
`timescale 1ns/1ps
`default_nettype none
module tftst_axis_counter
   import tftst_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // control
   input  wire logic         step,
   input  wire tftst_axis_t  intervals,
   // status
   output tftst_phase_t      phase,
   output logic              wrapPulse
);
   typedef struct packed {
      tftst_phase_t phase;
      logic [15:0]  count;
   } tftst_ax_state_t;

   tftst_ax_state_t state;
   tftst_ax_state_t next_state;
   logic [15:0]     limit;

   // length of current phase, zero counts as one
   always_comb begin
      case (state.phase)
         TFTST_SYNC:   limit = intervals.syncWidth;
         TFTST_BACK:   limit = intervals.backPorch;
         TFTST_ACTIVE: limit = intervals.activeCount;
         TFTST_FRONT:  limit = intervals.frontPorch;
         default:      limit = 16'h0001;
      endcase
   end

   always_comb begin
      next_state = state;
      wrapPulse  = 1'b0;
      if (step) begin
         if (state.count + 16'h0001 >= limit) begin
            next_state.count = 16'h0000;
            case (state.phase)
               TFTST_SYNC:   next_state.phase = TFTST_BACK;
               TFTST_BACK:   next_state.phase = TFTST_ACTIVE;
               TFTST_ACTIVE: next_state.phase = TFTST_FRONT;
               TFTST_FRONT: begin
                  next_state.phase = TFTST_SYNC;
                  wrapPulse        = 1'b1;
               end
               default:      next_state.phase = TFTST_SYNC;
            endcase
         end else begin
            next_state.count = state.count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '{phase: TFTST_SYNC, count: 16'h0000};
      end else begin
         state <= next_state;
      end
   end

   assign phase = state.phase;

   // phase never leaves the one-hot set
   onehot_phase_a: assert property (@(posedge clk) disable iff (reset)
      $onehot(state.phase))
      else $error("axis phase not one-hot");
endmodule // tftst_axis_counter
`default_nettype wire

// ---- logic/tftst_panel_timing.sv ----
// panel timing generator with avalon register slave and pixel clock divider
// assumes one 200 MHz clock, synchronous reset, master holds request
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tftst_consts.svh"
module tftst_panel_timing
   import tftst_pkg::*;
#(
   parameter int DELAY_WIDTH = 8
)(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // avalon-mm slave
   input  wire logic [5:0]   address,
   input  wire logic         read,
   input  wire logic         write,
   input  wire logic [31:0]  writedata,
   input  wire logic [3:0]   byteenable,
   output logic [31:0]       readdata,
   output logic              waitrequest,
   // panel pins
   output tftst_panel_t      panel
);
   initial begin
      if (DELAY_WIDTH < 1 || DELAY_WIDTH > 8) begin
         $error("DELAY_WIDTH must be 1 to 8");
      end
   end

   localparam logic [7:0] DIV_MIN = 8'(`TFTST_DIV_MIN);

   typedef struct packed {
      logic [31:0]  size;       // software copy
      logic [31:0]  lineParams;
      logic [31:0]  frameParams;
      logic [31:0]  activeSize; // copies used by counters
      logic [31:0]  activeLine;
      logic [31:0]  activeFrame;
      logic [1:0]   pol;
      logic [31:0]  clkDiv;
      logic         enable;
      logic [23:0]  pixelReg;
      logic [7:0]   divCount;
      logic         pclkRaw;
      logic [7:0]   delayLine;
      logic         acked;
      logic [31:0]  rdata;
      logic [15:0]  frameCount;
      tftst_panel_t pins;
   } tftst_state_t;

   tftst_state_t state;
   tftst_state_t next_state;
   logic         pixelStep;
   tftst_phase_t hPhase;
   tftst_phase_t vPhase;
   logic         lineWrap;
   logic         frameWrap;
   logic         hit;
   logic [31:0]  wMask;
   tftst_axis_t  hAxis;
   tftst_axis_t  vAxis;
   logic [7:0]   divLimit;

   // byte lane mask from byteenable
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wMask[i*8 +: 8] = {8{byteenable[i]}};
      end
   end

   // divider never goes below the fastest legal pixel clock
   always_comb begin
      divLimit = state.clkDiv[`TFTST_DIV_LSB +: 8];
      if (divLimit < DIV_MIN) begin
         divLimit = DIV_MIN;
      end
   end

   assign pixelStep = state.enable && !state.pclkRaw
                      && (state.divCount + 8'h01 >= divLimit);

   assign hAxis = '{
      syncWidth:   {8'h00, state.activeLine[`TFTST_PAR_SW_LSB +: 8]},
      backPorch:   {8'h00, state.activeLine[`TFTST_PAR_BP_LSB +: 8]},
      activeCount: state.activeSize[`TFTST_SIZE_X_LSB +: 16],
      frontPorch:  {8'h00, state.activeLine[`TFTST_PAR_FP_LSB +: 8]}};

   assign vAxis = '{
      syncWidth:   {8'h00, state.activeFrame[`TFTST_PAR_SW_LSB +: 8]},
      backPorch:   {8'h00, state.activeFrame[`TFTST_PAR_BP_LSB +: 8]},
      activeCount: state.activeSize[`TFTST_SIZE_Y_LSB +: 16],
      frontPorch:  {8'h00, state.activeFrame[`TFTST_PAR_FP_LSB +: 8]}};

   // pixel counter within a line
   tftst_axis_counter uLine (
      .clk       (clk),
      .reset     (reset || !state.enable),
      .step      (pixelStep),
      .intervals (hAxis),
      .phase     (hPhase),
      .wrapPulse (lineWrap)
   );

   // line counter within a frame
   tftst_axis_counter uFrame (
      .clk       (clk),
      .reset     (reset || !state.enable),
      .step      (lineWrap),
      .intervals (vAxis),
      .phase     (vPhase),
      .wrapPulse (frameWrap)
   );

   // one-cycle answer: wait on first cycle, release next
   assign hit         = (read || write) && !state.acked;
   assign waitrequest = (read || write) && !state.acked;
   assign readdata    = state.rdata;
   assign panel       = state.pins;

   always_comb begin
      next_state       = state;
      next_state.acked = 1'b0;
      // register access, taken once per request
      if (hit) begin
         next_state.acked = 1'b1;
         next_state.rdata = 32'h0000_0000;
         if (write) begin
            case (address)
               `TFTST_OFS_CTRL:   next_state.enable =
                  byteenable[0] ? writedata[0] : state.enable;
               `TFTST_OFS_SIZE:   next_state.size =
                  (state.size & ~wMask) | (writedata & wMask);
               `TFTST_OFS_LINE:   next_state.lineParams =
                  (state.lineParams & ~wMask) | (writedata & wMask);
               `TFTST_OFS_FRAME:  next_state.frameParams =
                  (state.frameParams & ~wMask) | (writedata & wMask);
               `TFTST_OFS_POL:    next_state.pol =
                  byteenable[0] ? writedata[1:0] : state.pol;
               `TFTST_OFS_CLKDIV: next_state.clkDiv =
                  (state.clkDiv & ~wMask) | (writedata & wMask);
               `TFTST_OFS_PIXEL:  next_state.pixelReg =
                  (state.pixelReg & ~wMask[23:0])
                  | (writedata[23:0] & wMask[23:0]);
               default: ;
            endcase
         end else begin
            case (address)
               `TFTST_OFS_CTRL:   next_state.rdata = {31'h0, state.enable};
               `TFTST_OFS_SIZE:   next_state.rdata = state.size;
               `TFTST_OFS_LINE:   next_state.rdata = state.lineParams;
               `TFTST_OFS_FRAME:  next_state.rdata = state.frameParams;
               `TFTST_OFS_POL:    next_state.rdata = {30'h0, state.pol};
               `TFTST_OFS_CLKDIV: next_state.rdata = state.clkDiv;
               `TFTST_OFS_STATUS: next_state.rdata =
                  {state.frameCount, 4'h0, state.pins.activeDataWindow,
                   state.pins.frameSync, state.pins.lineSync,
                   (vPhase == TFTST_ACTIVE), hPhase, vPhase};
               `TFTST_OFS_PIXEL:  next_state.rdata = {8'h00, state.pixelReg};
               default:           next_state.rdata = 32'h0000_0000;
            endcase
         end
      end

      // shadow copy at frame boundary, or while idle
      if (frameWrap || !state.enable) begin
         next_state.activeSize  = state.size;
         next_state.activeLine  = state.lineParams;
         next_state.activeFrame = state.frameParams;
      end
      if (frameWrap) begin
         next_state.frameCount = state.frameCount + 16'h0001;
      end

      // pixel clock divider: two toggles per pixel
      if (!state.enable) begin
         next_state.divCount = 8'h00;
         next_state.pclkRaw  = 1'b0;
      end else if (state.divCount + 8'h01 >= divLimit) begin
         next_state.divCount = 8'h00;
         next_state.pclkRaw  = !state.pclkRaw;
      end else begin
         next_state.divCount = state.divCount + 8'h01;
      end

      // delay line shifts the clock by whole system cycles; it takes the
      // new raw level so that delay zero rises in step with the data
      next_state.delayLine = {state.delayLine[6:0], next_state.pclkRaw};
      next_state.pins.pixelClock =
         next_state.delayLine[state.clkDiv[`TFTST_DLY_LSB +: 3]]
         ^ state.clkDiv[`TFTST_INV_BIT];

      if (pixelStep) begin
         next_state.pins.lineSync  =
            (hPhase == TFTST_SYNC) ^ state.pol[`TFTST_POL_LINE_BIT];
         next_state.pins.frameSync =
            (vPhase == TFTST_SYNC) ^ state.pol[`TFTST_POL_FRAME_BIT];
         next_state.pins.activeDataWindow =
            (hPhase == TFTST_ACTIVE) && (vPhase == TFTST_ACTIVE);
         next_state.pins.pixelData =
            ((hPhase == TFTST_ACTIVE) && (vPhase == TFTST_ACTIVE))
            ? state.pixelReg : 24'h000000;
      end
      if (!state.enable) begin
         next_state.pins.lineSync  = state.pol[`TFTST_POL_LINE_BIT];
         next_state.pins.frameSync = state.pol[`TFTST_POL_FRAME_BIT];
         next_state.pins.activeDataWindow = 1'b0;
         next_state.pins.pixelData = 24'h000000;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state             <= '0;
         state.size        <= `TFTST_RST_SIZE;
         state.lineParams  <= `TFTST_RST_LINE;
         state.frameParams <= `TFTST_RST_FRAME;
         state.activeSize  <= `TFTST_RST_SIZE;
         state.activeLine  <= `TFTST_RST_LINE;
         state.activeFrame <= `TFTST_RST_FRAME;
         state.pol         <= 2'(`TFTST_RST_POL);
         state.clkDiv      <= `TFTST_RST_CLKDIV;
      end else begin
         state <= next_state;
      end
   end

   // a request waits exactly one cycle, then completes
   sequence one_wait_s;
      waitrequest ##1 !waitrequest;
   endsequence

   one_wait_a: assert property (@(posedge clk) disable iff (reset)
      $rose(read || write) |-> one_wait_s)
      else $error("bus answer not after one wait");

   // syncs idle low right after reset
   sync_reset_a: assert property (@(posedge clk)
      $fell(reset) |-> !state.pins.lineSync && !state.pins.frameSync)
      else $error("syncs not low-idle after reset");

   // window only while the timing is enabled
   window_gate_a: assert property (@(posedge clk) disable iff (reset)
      state.pins.activeDataWindow |-> $past(state.enable))
      else $error("data window outside enabled timing");

   // window opens only on a pixel step inside both active phases
   window_phase_a: assert property (@(posedge clk) disable iff (reset)
      $rose(state.pins.activeDataWindow) |-> $past(pixelStep
      && hPhase == TFTST_ACTIVE && vPhase == TFTST_ACTIVE))
      else $error("data window opened outside active area");

   // while enabled, line sync moves only on a pixel step
   sync_edge_a: assert property (@(posedge clk) disable iff (reset)
      $changed(state.pins.lineSync) && $past(state.enable) && state.enable
      |-> $past(pixelStep))
      else $error("line sync changed off pixel edge");

   // line shadow intervals never change mid-frame
   frame_shadow_a: assert property (@(posedge clk) disable iff (reset)
      $changed(state.activeLine) |-> $past(frameWrap || !state.enable))
      else $error("line timing changed inside frame");

   // polarity bit inverts sync sense while idle
   sync_pol_a: assert property (@(posedge clk) disable iff (reset)
      !$past(state.enable) && !state.enable
      |-> state.pins.frameSync == $past(state.pol[1]))
      else $error("idle frame sync ignores polarity");

   // pixel steps never closer than the minimum period
   pixel_gap_a: assert property (@(posedge clk) disable iff (reset)
      pixelStep |=> !pixelStep [*3])
      else $error("pixel steps too close");

   // inversion bit flips the outgoing clock when no delay is set
   clk_invert_a: assert property (@(posedge clk) disable iff (reset)
      $stable(state.clkDiv) && state.clkDiv[10:8] == 3'h0 |->
      state.pins.pixelClock == (state.pclkRaw ^ state.clkDiv[16]))
      else $error("pixel clock inversion wrong");

   // plain clock: every line sync change while enabled comes with a clock rise
   pixel_align_a: assert property (@(posedge clk) disable iff (reset)
      (state.clkDiv[10:8] == 3'h0 && !state.clkDiv[16]) [*2] ##1
      ($changed(state.pins.lineSync) && $past(state.enable) && state.enable)
      |-> $rose(state.pins.pixelClock))
      else $error("line sync not on pixel clock rise");
endmodule // tftst_panel_timing
`default_nettype wire

// ---- verif/tftst_panel_model.sv ----
// panel model: samples the pins on the falling pixel clock edge and
// measures line and frame intervals for the bench to compare
// assumes sync levels are told by the bench and a running pixel clock
`timescale 1ns/1ps
`default_nettype none
module tftst_panel_model
   import tftst_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // panel pins and expected inactive-high sync levels
   input  wire tftst_panel_t panel,
   input  wire logic         lineLow,
   input  wire logic         frameLow,
   // measurements
   output logic [15:0]       syncPix,
   output logic [15:0]       backPix,
   output logic [15:0]       linePix,
   output logic [15:0]       windowPix,
   output logic [15:0]       syncLines,
   output logic [15:0]       backLines,
   output logic [15:0]       frameLines,
   output logic [15:0]       windowLines,
   output logic [15:0]       clkPerPix,
   output logic [15:0]       winLag,
   output logic [15:0]       frames,
   output logic [23:0]       lastData,
   output logic              stray
);
   logic        prevClk, prevWin, vsLine, armed, hs, vs, win, fall, rise;
   logic [15:0] pc, sc, bc, wc, lc, vc, dc, vb, cc, lagCnt;

   // asserted levels as the panel sees them
   assign hs   = panel.lineSync ^ lineLow;
   assign vs   = panel.frameSync ^ frameLow;
   assign win  = panel.activeDataWindow;
   assign fall = prevClk & ~panel.pixelClock;
   assign rise = ~prevClk & panel.pixelClock;

   // behavioural capture; a line starts where line sync turns asserted
   always @(posedge clk) begin
      if (reset) begin
         {prevClk, prevWin, vsLine, armed, stray} <= 5'h00;
         {pc, sc, bc, wc, lc, vc, dc, vb, cc, lagCnt, frames} <= '0;
      end else begin
         prevClk <= panel.pixelClock;
         prevWin <= win;
         cc      <= fall ? 16'h0001 : cc + 16'h0001;
         if (fall)
            clkPerPix <= cc;
         // phase of the pixel clock against the data it qualifies
         if (win && !prevWin) begin
            armed  <= !rise;
            lagCnt <= 16'h0001;
            if (rise)
               winLag <= 16'h0000;
         end else if (armed) begin
            if (rise) begin
               winLag <= lagCnt;
               armed  <= 1'b0;
            end
            lagCnt <= lagCnt + 16'h0001;
         end
         if (fall) begin
            if (win)
               lastData <= panel.pixelData;
            // data outside the window would be shown as garbage
            if (!win && panel.pixelData != 24'h000000)
               stray <= 1'b1;
            // sync after non-sync pixels opens a new line
            if (hs && pc != sc) begin
               linePix   <= pc;
               syncPix   <= sc;
               // porch and window only mean something on active lines
               if (wc != 16'h0000) begin
                  backPix   <= bc;
                  windowPix <= wc;
               end
               {pc, sc, bc, wc} <= {16'h0001, 16'h0001, 32'h0};
               vsLine    <= vs;
               if (vs && !vsLine) begin
                  frameLines  <= lc;
                  syncLines   <= vc;
                  backLines   <= vb;
                  windowLines <= dc + 16'(wc != 16'h0000);
                  frames      <= frames + 16'h0001;
                  {lc, vc, dc, vb} <= {16'h0001, 16'h0001, 32'h0};
               end else begin
                  lc <= lc + 16'h0001;
                  vc <= vc + 16'(vs);
                  dc <= dc + 16'(wc != 16'h0000);
                  if (!vsLine && wc == 16'h0000 && dc == 16'h0000)
                     vb <= vb + 16'h0001;
               end
            end else begin
               pc <= pc + 16'h0001;
               sc <= (hs && sc == pc) ? sc + 16'h0001 : sc;
               wc <= wc + 16'(win);
               if (!hs && !win && wc == 16'h0000)
                  bc <= bc + 16'h0001;
            end
         end
      end
   end
endmodule // tftst_panel_model
`default_nettype wire

// ---- verif/tftst_panel_timing_bench.sv ----
// bench for the panel timing block: avalon register tasks and checks of
// the line and frame intervals measured by the panel model
// assumes one 200 MHz clock and the small timing values set below
`timescale 1ns/1ps
`default_nettype none
`include "tftst_consts.svh"
module tftst_panel_timing_bench
   import tftst_pkg::*;
;
   logic         clk, reset, read, write, waitrequest, stray;
   logic         lineLow, frameLow;
   logic [5:0]   address;
   logic [3:0]   byteenable;
   logic [31:0]  writedata, readdata, rdata;
   logic [23:0]  lastData;
   logic [15:0]  syncPix, backPix, linePix, windowPix, syncLines, frames;
   logic [15:0]  backLines, frameLines, windowLines, clkPerPix, winLag;
   tftst_panel_t panel;
   int           numErrors, numChecks;
   // divider 1 is below the fastest legal pixel clock and gets clamped
   logic [31:0]  clkCfg [3] = '{32'h0000_0001, 32'h0000_0203, 32'h0001_0003};
   logic [31:0]  lagExp [3] = '{32'h0, 32'h2, 32'h3};

   tftst_panel_timing u_dut (.clk(clk), .reset(reset), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .panel(panel));

   tftst_panel_model u_panel (.clk(clk), .reset(reset), .panel(panel),
      .lineLow(lineLow), .frameLow(frameLow), .syncPix(syncPix),
      .backPix(backPix), .linePix(linePix), .windowPix(windowPix),
      .syncLines(syncLines), .backLines(backLines),
      .frameLines(frameLines), .windowLines(windowLines),
      .clkPerPix(clkPerPix), .winLag(winLag), .frames(frames),
      .lastData(lastData), .stray(stray));

   // clock
   always #2.5 clk = ~clk;

   task automatic stopTest();
      $display("checks %0d errors %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      numChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h",
                  $time, what, got, exp);
      end
   endtask

   // one avalon access; request held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [5:0] addr,
                         input logic [31:0] data);
      int n;
      address    <= addr;
      writedata  <= data;
      byteenable <= 4'hF;
      write      <= wr;
      read       <= !wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      if (waitrequest !== 1'b0) begin
         check(32'h1, 32'h0, "bus answer");
         stopTest();
      end
      rdata = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic regRead(input logic [5:0] a, input logic [31:0] exp,
                          input string what);
      access(1'b0, a, 32'h0);
      check(rdata, exp, what);
   endtask

   // bounded wait for whole frames seen by the panel
   task automatic waitFrames(input int n);
      logic [15:0] target;
      int          k;
      target = frames + 16'(n);
      k = 0;
      while (frames !== target && k < 8000) begin
         @(posedge clk);
         k++;
      end
      if (frames !== target) begin
         check(32'h1, 32'h0, "frame wait");
         stopTest();
      end
   endtask

   // main sequence
   initial begin
      {clk, read, write, lineLow, frameLow} = 5'h00;
      reset = 1'b1;
      address = 6'h00;
      writedata = 32'h0;
      byteenable = 4'h0;
      numErrors = 0;
      numChecks = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check(32'(panel), 32'h0, "idle pins");
      regRead(`TFTST_OFS_CTRL, 32'h0, "ctrl reset");
      regRead(`TFTST_OFS_SIZE, `TFTST_RST_SIZE, "size reset");
      regRead(`TFTST_OFS_LINE, `TFTST_RST_LINE, "line reset");
      regRead(`TFTST_OFS_FRAME, `TFTST_RST_FRAME, "frame reset");
      regRead(`TFTST_OFS_POL, `TFTST_RST_POL, "polarity reset");
      access(1'b1, 6'h20, 32'hFFFF_FFFF);
      regRead(6'h20, 32'h0, "unmapped read");
      // four active pixels, two active lines, frame 1+1+2+2 lines
      access(1'b1, `TFTST_OFS_SIZE, 32'h0002_0004);
      access(1'b1, `TFTST_OFS_FRAME, 32'h0002_0101);
      access(1'b1, `TFTST_OFS_PIXEL, 32'h00A5_C3E1);
      access(1'b1, `TFTST_OFS_CLKDIV, 32'h0000_0003);
      access(1'b1, `TFTST_OFS_CTRL, 32'h0000_0001);
      regRead(`TFTST_OFS_PIXEL, 32'h00A5_C3E1, "pixel readback");
      // each pass a new back porch and a new sync polarity pair
      for (int p = 0; p < 4; p++) begin
         access(1'b1, `TFTST_OFS_LINE, {16'h0003, 8'(p + 1), 8'h02});
         access(1'b1, `TFTST_OFS_POL, 32'(p));
         lineLow  <= p[0];
         frameLow <= p[1];
         waitFrames(3);
         check(32'(syncPix), 32'h2, "line sync width");
         check(32'(backPix), 32'(p + 1), "line back porch");
         check(32'(linePix), 32'(p + 10), "line period");
         check(32'(windowPix), 32'h4, "window pixels");
         check(32'(syncLines), 32'h1, "frame sync lines");
         check(32'(backLines), 32'h1, "frame back porch");
         check(32'(frameLines), 32'h6, "frame period");
         check(32'(windowLines), 32'h2, "window lines");
         check(32'(lastData), 32'h00A5_C3E1, "pixel data");
      end
      // pixel clock: clamped divider, delay, inversion
      for (int c = 0; c < 3; c++) begin
         access(1'b1, `TFTST_OFS_CLKDIV, clkCfg[c]);
         regRead(`TFTST_OFS_CLKDIV, clkCfg[c], "divider readback");
         waitFrames(3);
         check(32'(clkPerPix), 32'h6, "pixel clock period");
         check(32'(winLag), lagExp[c], "pixel clock phase");
      end
      check(32'(stray), 32'h0, "data outside window");
      stopTest();
   end
endmodule // tftst_panel_timing_bench
`default_nettype wire
